// ### pkg/pvs_consts.svh
// register offsets, field positions and reset values of the vendor management registers
`ifndef PVS_CONSTS_SVH
`define PVS_CONSTS_SVH
`define PVS_ADDR_RX_TALLY 5'h15
`define PVS_ADDR_INT_CS 5'h1b
`define PVS_ADDR_XCVR_CTL 5'h1f
`define PVS_TALLY_RST 16'h0000
`define PVS_TALLY_ONE 16'h0001
`define PVS_TALLY_MAX 16'hffff
`define PVS_INT_EN_HI 15
`define PVS_INT_EN_LO 8
`define PVS_INT_FLAG_HI 7
`define PVS_INT_FLAG_LO 0
`define PVS_N_SRC 8
`define PVS_CTL_XOVER_OFF 13
`define PVS_CTL_ENERGY 12
`define PVS_CTL_FORCE_LINK 11
`define PVS_CTL_PWR_SAVE 10
`define PVS_CTL_INT_LEVEL 9
`define PVS_CTL_JABBER_EN 8
`define PVS_CTL_ANEG_DONE 7
`define PVS_CTL_PAUSE 6
`define PVS_CTL_ISOLATE 5
`define PVS_CTL_SQE 1
`define PVS_CTL_SCR_BYP 0
`define PVS_CTL_RW_MASK 16'h2f83
`define PVS_CTL_RST 16'h0500
`define PVS_DATA_ZERO 16'h0000
`define PVS_INT_IDLE 1'b1
`define PVS_SYNC_W 13
`define PVS_SYNC_EVT_HI 7
`define PVS_SYNC_EVT_LO 0
`define PVS_SYNC_RX_ERR 8
`define PVS_SYNC_ENERGY 9
`define PVS_SYNC_ANEG 10
`define PVS_SYNC_PAUSE 11
`define PVS_SYNC_ISO 12
`endif

// ### pkg/pvs_pkg.sv
// types shared by the vendor management register bank
package pvs_pkg;
  typedef logic [15:0] pvs_word_type;
  typedef logic [4:0] pvs_addr_type;
  typedef logic [7:0] pvs_src_type;
endpackage

// ### pkg/pvs_evt_if.sv
// event sources and their latched flags passed between bank and flag module
`timescale 1ns/1ps
interface pvs_evt_if;
  import pvs_pkg::*;
  pvs_src_type evt;
  pvs_src_type flags;
  logic rd_clear;
  modport bank (output evt, output rd_clear, input flags);
  modport flag (input evt, input rd_clear, output flags);
endinterface

// ### verilog/pvs_event_flags.sv
// eight sticky event flags cleared by a read of the interrupt register
`timescale 1ns/1ps
`include "pvs_consts.svh"
module pvs_event_flags (
  input wire logic i_clk,
  input wire logic i_rst,
  pvs_evt_if.flag evt_if
);
  import pvs_pkg::*;
  pvs_src_type flags_reg;
  pvs_src_type flags_next;
  genvar g;
  // ----------------------------------------
  // flag update
  // ----------------------------------------
  generate
    for (g = 0; g < `PVS_N_SRC; g = g + 1) begin : g_flag
      always_comb begin
        // set wins over the read clear
        flags_next[g] = evt_if.evt[g] | (flags_reg[g] & ~evt_if.rd_clear);
      end
    end
  endgenerate
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end
  assign evt_if.flags = flags_reg;
endmodule

// ### verilog/pvs_regs.sv
// vendor status and control register bank of a 10/100 transceiver
//
// Notes on behaviour
// - Register 15h counts receive error events and reads zero after reset.
// - Bits 15..8 of 1bh are writable enables for jabber, rx error, page, pd fault, ack, link down, remote fault, link up, reset 0.
// - Bits 7..0 of 1bh are event flags in the same order, set by the event and cleared by a read.
// - Interrupt output is active high when 1f.9 is one and active low when zero.
// - 1f.13 set turns off automatic crossover; reset zero keeps it on.
// - 1f.12 reads one while receive energy is present.
// - 1f.11 set forces link pass so the transmitter runs without link.
// - 1f.10 enables power saving and resets to one.
// - 1f.8 lets the jabber counter run and resets to one.
// - 1f.7 shows one once auto-negotiation is complete, reset zero.
// - 1f.6 reports the resolved flow control result.
// - 1f.5 reads one while the transceiver is isolated.
// - 1f.1 set enables the SQE test, reset zero.
// - 1f.0 set bypasses the transmit scrambler, reset zero.
`timescale 1ns/1ps
`include "pvs_consts.svh"
module pvs_regs (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire pvs_pkg::pvs_addr_type i_addr,
  input wire pvs_pkg::pvs_word_type i_wdata,
  output logic [15:0] o_rdata,
  input wire logic i_rx_err,
  input wire pvs_pkg::pvs_src_type i_evt,
  input wire logic i_energy,
  input wire logic i_aneg_done,
  input wire logic i_pause_ok,
  input wire logic i_isolated,
  output logic o_int,
  output logic o_xover_off,
  output logic o_force_link,
  output logic o_pwr_save,
  output logic o_jabber_en,
  output logic o_sqe_test,
  output logic o_scr_bypass
);
  import pvs_pkg::*;
  pvs_evt_if evt_if ();
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [`PVS_SYNC_W-1:0] meta_reg;
  logic [`PVS_SYNC_W-1:0] sync_reg;
  logic [`PVS_SYNC_W-1:0] meta_next;
  logic [`PVS_SYNC_W-1:0] sync_next;
  logic rx_err_prev_reg;
  logic rx_err_prev_next;
  pvs_src_type evt_prev_reg;
  pvs_src_type evt_prev_next;
  always_comb begin
    meta_next = {i_isolated, i_pause_ok, i_aneg_done, i_energy, i_rx_err, i_evt};
    sync_next = meta_reg;
    rx_err_prev_next = sync_reg[`PVS_SYNC_RX_ERR];
    evt_prev_next = sync_reg[`PVS_SYNC_EVT_HI:`PVS_SYNC_EVT_LO];
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      rx_err_prev_reg <= 1'b0;
      evt_prev_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      rx_err_prev_reg <= rx_err_prev_next;
      evt_prev_reg <= evt_prev_next;
    end
  end
  logic rx_err_s;
  logic energy_s;
  logic aneg_s;
  logic pause_s;
  logic iso_s;
  assign rx_err_s = sync_reg[`PVS_SYNC_RX_ERR];
  assign energy_s = sync_reg[`PVS_SYNC_ENERGY];
  assign aneg_s = sync_reg[`PVS_SYNC_ANEG];
  assign pause_s = sync_reg[`PVS_SYNC_PAUSE];
  // only the second stage is read; the first one may still be settling
  assign iso_s = sync_reg[`PVS_SYNC_ISO];
  // ----------------------------------------
  // event flags
  // ----------------------------------------
  // address match shared by the read and write decoders
  function automatic logic addr_is(input pvs_addr_type addr, input pvs_addr_type target);
    return addr == target;
  endfunction
  logic rd_int;
  logic wr_int;
  logic wr_ctl;
  assign rd_int = i_rd && addr_is(i_addr, `PVS_ADDR_INT_CS);
  assign wr_int = i_wr && addr_is(i_addr, `PVS_ADDR_INT_CS);
  assign wr_ctl = i_wr && addr_is(i_addr, `PVS_ADDR_XCVR_CTL);
  // rising edge of each synchronised source level
  assign evt_if.evt = sync_reg[`PVS_SYNC_EVT_HI:`PVS_SYNC_EVT_LO] & ~evt_prev_reg;
  assign evt_if.rd_clear = rd_int;
  pvs_event_flags u_flags (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .evt_if(evt_if.flag)
  );
  // ----------------------------------------
  // receive error tally
  // ----------------------------------------
  pvs_word_type tally_reg;
  pvs_word_type tally_next;
  logic rx_err_rise;
  always_comb begin
    rx_err_rise = rx_err_s && !rx_err_prev_reg;
    tally_next = tally_reg;
    // saturate so a long error burst cannot wrap back to a small count
    if (rx_err_rise && (tally_reg != `PVS_TALLY_MAX)) begin
      tally_next = tally_reg + `PVS_TALLY_ONE;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tally_reg <= `PVS_TALLY_RST;
    end else begin
      tally_reg <= tally_next;
    end
  end
  // ----------------------------------------
  // interrupt enables
  // ----------------------------------------
  pvs_src_type int_en_reg;
  pvs_src_type int_en_next;
  always_comb begin
    int_en_next = int_en_reg;
    // the flag byte of the same word is read-only and dropped here
    if (wr_int) begin
      int_en_next = i_wdata[`PVS_INT_EN_HI:`PVS_INT_EN_LO];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      int_en_reg <= '0;
    end else begin
      int_en_reg <= int_en_next;
    end
  end
  // ----------------------------------------
  // transceiver control
  // ----------------------------------------
  pvs_word_type ctl_reg;
  pvs_word_type ctl_next;
  always_comb begin
    ctl_next = ctl_reg;
    if (wr_ctl) begin
      ctl_next = i_wdata & `PVS_CTL_RW_MASK;
    end
    // completion status follows the negotiation engine, not the write
    ctl_next[`PVS_CTL_ANEG_DONE] = aneg_s;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl_reg <= `PVS_CTL_RST;
    end else begin
      ctl_reg <= ctl_next;
    end
  end
  // ----------------------------------------
  // read-back
  // ----------------------------------------
  pvs_word_type rdata_reg;
  pvs_word_type rdata_next;
  always_comb begin
    rdata_next = `PVS_DATA_ZERO;
    if (i_rd) begin
      unique case (i_addr)
        `PVS_ADDR_RX_TALLY: rdata_next = tally_reg;
        `PVS_ADDR_INT_CS: rdata_next = {int_en_reg, evt_if.flags};
        `PVS_ADDR_XCVR_CTL: begin
          rdata_next = ctl_reg;
          rdata_next[`PVS_CTL_ENERGY] = energy_s;
          rdata_next[`PVS_CTL_PAUSE] = pause_s;
          rdata_next[`PVS_CTL_ISOLATE] = iso_s;
        end
        default: rdata_next = `PVS_DATA_ZERO;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= `PVS_DATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  // ----------------------------------------
  // interrupt pin
  // ----------------------------------------
  logic int_reg;
  logic int_next;
  logic int_active;
  always_comb begin
    int_active = |(int_en_reg & evt_if.flags);
    // active low out of reset, so the idle pin level is high
    int_next = ctl_reg[`PVS_CTL_INT_LEVEL] ? int_active : ~int_active;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      int_reg <= `PVS_INT_IDLE;
    end else begin
      int_reg <= int_next;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_rdata = rdata_reg;
  assign o_int = int_reg;
  assign o_xover_off = ctl_reg[`PVS_CTL_XOVER_OFF];
  assign o_force_link = ctl_reg[`PVS_CTL_FORCE_LINK];
  assign o_pwr_save = ctl_reg[`PVS_CTL_PWR_SAVE];
  assign o_jabber_en = ctl_reg[`PVS_CTL_JABBER_EN];
  assign o_sqe_test = ctl_reg[`PVS_CTL_SQE];
  assign o_scr_bypass = ctl_reg[`PVS_CTL_SCR_BYP];
endmodule

// ### tb/pvs_regs_properties.sv
// checker for the vendor register bank ports
`timescale 1ns/1ps
module pvs_regs_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire pvs_pkg::pvs_addr_type i_addr,
  input wire pvs_pkg::pvs_word_type i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic o_xover_off,
  input wire logic o_force_link,
  input wire logic o_pwr_save,
  input wire logic o_jabber_en,
  input wire logic o_sqe_test,
  input wire logic o_scr_bypass
);
  import pvs_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_wr; i_wr && i_addr == 5'h1f; endsequence
  sequence s_rd; i_rd && !i_wr && i_addr == 5'h1f; endsequence
  a_rsvd_zero: assert property (s_rd |=> (o_rdata & 16'hc01c) == 16'h0)
    else $error("rsvd");
  a_xover_wr: assert property (s_wr |=> o_xover_off == $past(i_wdata[13]))
    else $error("xover");
  a_force_wr: assert property (s_wr |=> o_force_link == $past(i_wdata[11]))
    else $error("force");
  a_pwr_wr: assert property (s_wr |=> o_pwr_save == $past(i_wdata[10]))
    else $error("pwr");
  a_jab_wr: assert property (s_wr |=> o_jabber_en == $past(i_wdata[8]))
    else $error("jab");
  a_sqe_wr: assert property (s_wr |=> o_sqe_test == $past(i_wdata[1]))
    else $error("sqe");
  a_scr_wr: assert property (s_wr |=> o_scr_bypass == $past(i_wdata[0]))
    else $error("scr");
  a_ctl_hold: assert property (!(i_wr && i_addr == 5'h1f) |=> $stable({o_xover_off,
    o_force_link, o_pwr_save, o_jabber_en, o_sqe_test, o_scr_bypass})) else $error("hold");
endmodule
bind pvs_regs pvs_regs_chk u_chk (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .o_rdata(o_rdata),
  .o_xover_off(o_xover_off),
  .o_force_link(o_force_link),
  .o_pwr_save(o_pwr_save),
  .o_jabber_en(o_jabber_en),
  .o_sqe_test(o_sqe_test),
  .o_scr_bypass(o_scr_bypass)
);

// ### tb/pvs_mgmt_model.sv
// management controller model issuing register reads and writes
`timescale 1ns/1ps
module pvs_mgmt_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [4:0] o_addr,
  output logic [15:0] o_wdata
);
  initial begin
    o_wr = 0;
    o_rd = 0;
    o_addr = 5'h00;
    o_wdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge i_clk);
    o_wr = 1;
    o_addr = a;
    o_wdata = v;
    @(negedge i_clk);
    o_wr = 0;
    o_addr = ~a;
    o_wdata = ~v;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(negedge i_clk);
    o_rd = 1;
    o_addr = a;
    @(negedge i_clk);
    v = i_rdata;
    o_rd = 0;
    o_addr = ~a;
  endtask
endmodule

// ### tb/tb_pvs_regs.sv
// self-checking bench for the vendor register bank
`timescale 1ns/1ps
module tb_pvs_regs;
  import pvs_pkg::*;
  logic i_clk = 0, i_rst = 1, i_rx_err = 0, i_energy = 0, i_aneg_done = 0;
  logic i_pause_ok = 0, i_isolated = 0, i_wr, i_rd, o_int, o_xover_off, o_force_link;
  logic o_pwr_save, o_jabber_en, o_sqe_test, o_scr_bypass;
  pvs_addr_type i_addr;
  pvs_word_type i_wdata, d;
  pvs_src_type i_evt = 8'h00;
  logic [15:0] o_rdata;
  logic [15:0] ctl;
  int err_total = 0, tests_run = 0, cyc = 0;
  assign ctl = {10'h0, o_xover_off, o_force_link, o_pwr_save, o_jabber_en, o_sqe_test,
    o_scr_bypass};
  pvs_regs DUT (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .i_rx_err(i_rx_err),
    .i_evt(i_evt),
    .i_energy(i_energy),
    .i_aneg_done(i_aneg_done),
    .i_pause_ok(i_pause_ok),
    .i_isolated(i_isolated),
    .o_int(o_int),
    .o_xover_off(o_xover_off),
    .o_force_link(o_force_link),
    .o_pwr_save(o_pwr_save),
    .o_jabber_en(o_jabber_en),
    .o_sqe_test(o_sqe_test),
    .o_scr_bypass(o_scr_bypass)
  );
  pvs_mgmt_model mac (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
    .o_addr(i_addr), .o_wdata(i_wdata));
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rchk(input string n, input pvs_addr_type a, input logic [15:0] e);
    mac.rd(a, d);
    chk(n, d, e);
  endtask
  task automatic t_reset();
    rchk("tally", 5'h15, 16'h0000);
    rchk("intcs", 5'h1b, 16'h0000);
    rchk("ctl", 5'h1f, 16'h0500);
    chk("ctlo", ctl, 16'h000c);
    chk("int_rst", 16'(o_int), 16'h0001);
    $display("t_reset done");
  endtask
  task automatic t_ctl();
    i_energy = 1;
    i_pause_ok = 1;
    i_aneg_done = 1;
    mac.wr(5'h1f, 16'hffff);
    repeat (4) @(negedge i_clk);
    rchk("ctl1", 5'h1f, 16'h3fc3);
    chk("ctlo1", ctl, 16'h003f);
    chk("int1", 16'(o_int), 16'h0000);
    i_energy = 0;
    i_pause_ok = 0;
    i_aneg_done = 0;
    i_isolated = 1;
    mac.wr(5'h1f, 16'h0000);
    repeat (4) @(negedge i_clk);
    rchk("ctl0", 5'h1f, 16'h0020);
    chk("ctlo0", ctl, 16'h0000);
    chk("int0", 16'(o_int), 16'h0001);
    $display("t_ctl done");
  endtask
  task automatic t_int();
    mac.wr(5'h1b, 16'hffff);
    for (int i = 0; i < 8; i++) begin
      i_evt = 8'h01 << i;
      repeat (5) @(negedge i_clk);
      chk("intlo", 16'(o_int), 16'h0000);
      rchk("flag", 5'h1b, {8'hff, i_evt});
      repeat (2) @(negedge i_clk);
      chk("inthi", 16'(o_int), 16'h0001);
      rchk("clr", 5'h1b, 16'hff00);
      i_evt = 8'h00;
      @(negedge i_clk);
    end
    mac.wr(5'h1b, 16'h0000);
    i_evt = 8'h80;
    repeat (5) @(negedge i_clk);
    chk("mask", 16'(o_int), 16'h0001);
    rchk("mflag", 5'h1b, 16'h0080);
    $display("t_int done");
  endtask
  task automatic t_tally();
    repeat (3) begin
      i_rx_err = 1;
      repeat (3) @(negedge i_clk);
      i_rx_err = 0;
      repeat (3) @(negedge i_clk);
    end
    mac.wr(5'h15, 16'hffff);
    rchk("tally3", 5'h15, 16'h0003);
    rchk("unmap", 5'h02, 16'h0000);
    $display("t_tally done");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    i_rst = 0;
    t_reset();
    t_ctl();
    t_int();
    t_tally();
    wrap_up();
  end
endmodule
